// ### src/bridge_primary_command_status.sv
// Primary command and status registers with forwarding gates and event interrupt.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Fast back-to-back bit 9 is read/write, resets 0, never causes back-to-back cycles.
// - Command bit 8 gates the system-error driver; cleared at reset keeps it idle.
// - Command bit 7 always reads zero and ignores writes.
// - Command bit 6 enables parity reaction; cleared suppresses status bit 8 only, while bit 15 still sets.
// - Snoop enable forwards primary I/O writes to palette ports 3C6h, 3C8h, 3C9h.
// - Palette decode compares only address bits nine to zero.
// - Command bit 4 is read-only zero.
// - Command bit 3 is read-only zero; no special cycle response.
// - Command bit 2 permits primary mastering; resets clear, no cycle while clear.
// - With bus master enable clear, secondary memory and I/O transactions are ignored.
// - Memory forwarding only while command bit 1 is set; resets clear.
// - I/O forwarding only while command bit 0 is set; resets clear.
// - Writing one clears a writable status bit; writing zero leaves it.
// - Only status bits 15 to 11 and 8 are clearable; others read-only.
// - Status bit 14 sets when system error is signalled with its enable set.
// - Status 13, 12 on received master/target abort; 11 on signalled target abort.
// - Status bit 8 sets on master data parity error with parity response enabled.
// - Status bits 10:9 read 01b, bit 4 reads 1, bits 7 to 5 read 0.
module bridge_primary_command_status
	import bridge_cmd_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_ce,
	input  wire logic [3:0]    i_avs_address,
	input  wire logic          i_avs_read,
	input  wire logic          i_avs_write,
	input  wire logic [31:0]   i_avs_writedata,
	input  wire logic [3:0]    i_avs_byteenable,
	output logic [31:0]        o_avs_readdata,
	output logic               o_avs_waitrequest,
	input  wire bridge_event_s i_event,
	input  wire logic          i_pri_io_write,
	input  wire logic [31:0]   i_pri_addr,
	input  wire logic          i_pri_master_req,
	input  wire logic          i_sec_mem_io_req,
	output fwd_gate_s          o_gate,
	output logic               o_syserr_drive,
	output logic               o_irq
);

	logic [15:0]   cmd_r;
	logic [15:0]   st_r;
	logic [5:0]    irq_st_r;
	logic [5:0]    irq_mask_r;
	logic [31:0]   rdata_r;
	logic          ack_r;
	logic          snoop_hit;
	logic          wr_cmd;
	logic          wr_st;
	logic          wr_mask;
	logic          rd_irq;
	logic          req;
	logic          acc;
	logic [5:0]    irq_st_nxt;
	logic [5:0]    irq_mask_nxt;
	logic [15:0]   wdata16;
	logic [15:0]   st_set;
	logic [15:0]   st_clr;
	logic [5:0]    ev_vec;

	// Registers answer one cycle after the request, so waitrequest drops then.
	// Side effects wait for the edge at which waitrequest is low.
	assign req = (i_avs_read || i_avs_write) && !ack_r;
	assign acc = (i_avs_read || i_avs_write) && ack_r && i_ce;
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !acc;

	function automatic logic [15:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	assign wdata16 = i_avs_writedata[15:0] & lane_mask(i_avs_byteenable);
	assign wr_cmd  = acc && i_avs_write && i_avs_address == ADDR_COMMAND;
	assign wr_st   = acc && i_avs_write && i_avs_address == ADDR_STATUS;
	assign wr_mask = acc && i_avs_write && i_avs_address == ADDR_IRQ_MASK;
	assign rd_irq  = acc && i_avs_read && i_avs_address == ADDR_IRQ_STATUS;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_r <= 1'b0;
		end else if (i_ce) begin
			ack_r <= req;
		end
	end

	// fast back-to-back bit is storage only.
	// wait cycle control masked out of writes.
	// invalidate enable masked out of writes.
	// special cycle enable masked out of writes.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_r <= CMD_RESET;
		end else if (wr_cmd) begin
			cmd_r <= (cmd_r & ~(lane_mask(i_avs_byteenable) & CMD_WRITABLE)) |
				(wdata16 & CMD_WRITABLE);
		end
	end

	// system-error driver gated by the enable.
	assign o_syserr_drive = cmd_r[CMD_SYSERR_EN] && i_event.syserr_request;

	// data parity flag gated by parity response.
	always_comb begin
		st_set = 16'h0000;
		st_set[ST_DET_PARITY] = i_event.parity_detected;
		st_set[ST_SIG_SYSERR] = o_syserr_drive;
		st_set[ST_RCV_MABORT] = i_event.master_abort_rcvd;
		st_set[ST_RCV_TABORT] = i_event.target_abort_rcvd;
		st_set[ST_SIG_TABORT] = i_event.target_abort_sig;
		st_set[ST_DATA_PAR]   = i_event.data_parity_master && cmd_r[CMD_PARITY_EN];
	end

	// write one to clear, zero leaves the bit.
	assign st_clr = wr_st ? (wdata16 & ST_CLEARABLE) : 16'h0000;

	// the set term is applied after the clear.
	// fixed bits forced on every update.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= ST_RESET;
		end else if (i_ce) begin
			st_r <= (((st_r & ~st_clr) | st_set) & ST_CLEARABLE) | ST_FIXED;
		end
	end

	assign ev_vec = {st_set[ST_DET_PARITY], st_set[ST_SIG_SYSERR], st_set[ST_RCV_MABORT],
		st_set[ST_RCV_TABORT], st_set[ST_SIG_TABORT], st_set[ST_DATA_PAR]};

	// A read clears only what it returned, so an event during the access is not lost.
	always_comb begin
		irq_st_nxt = irq_st_r;
		if (rd_irq) begin
			irq_st_nxt = irq_st_r & ~rdata_r[5:0];
		end
		irq_st_nxt = irq_st_nxt | ev_vec;
	end

	always_comb begin
		irq_mask_nxt = irq_mask_r;
		if (wr_mask && i_avs_byteenable[0]) begin
			irq_mask_nxt = i_avs_writedata[5:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_st_r <= 6'h00;
		end else if (i_ce) begin
			irq_st_r <= irq_st_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_mask_r <= 6'h00;
		end else if (i_ce) begin
			irq_mask_r <= irq_mask_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq <= |(irq_st_nxt & irq_mask_nxt);
		end
	end

	// Unmapped addresses read as zero and writes to them are dropped.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (i_ce && req && i_avs_read) begin
			case (i_avs_address)
				ADDR_COMMAND:    rdata_r <= {16'h0000, cmd_r & CMD_WRITABLE};
				ADDR_STATUS:     rdata_r <= {16'h0000, st_r};
				ADDR_IRQ_STATUS: rdata_r <= {26'h0000000, irq_st_r};
				ADDR_IRQ_MASK:   rdata_r <= {26'h0000000, irq_mask_r};
				default:         rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign o_avs_readdata = rdata_r;

	palette_snoop u_snoop (
		.i_enable   (cmd_r[CMD_SNOOP_EN]),
		.i_io_write (i_pri_io_write),
		.i_addr     (i_pri_addr),
		.o_hit      (snoop_hit)
	);

	// primary mastering only with bus master enable.
	// secondary requests refused without bus master enable.
	always_comb begin
		o_gate.fwd_mem    = cmd_r[CMD_MEM_EN];
		o_gate.fwd_io     = cmd_r[CMD_IO_EN];
		o_gate.master_ok  = cmd_r[CMD_MASTER_EN] && i_pri_master_req;
		o_gate.sec_accept = cmd_r[CMD_MASTER_EN] && i_sec_mem_io_req;
		o_gate.snoop_fwd  = snoop_hit;
		o_gate.fast_b2b   = 1'b0;
	end

	// Read-only command bits stay zero whatever is written.
	a_cmd_ro_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cmd_r & ~CMD_WRITABLE) == 16'h0000)
		else $error("read-only command bit set");

	a_cmd_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_cmd && i_avs_byteenable[1:0] == 2'b11 |=>
		cmd_r == ($past(i_avs_writedata[15:0]) & CMD_WRITABLE))
		else $error("command write not stored");

	a_cmd_ro_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && req && i_avs_read && i_avs_address == ADDR_COMMAND |=>
		!rdata_r[CMD_MWI] && !rdata_r[CMD_SPECIAL] && !rdata_r[CMD_WAIT_CTL])
		else $error("read-only command bit read as one");

	a_syserr_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_syserr_drive |-> cmd_r[CMD_SYSERR_EN])
		else $error("system error driven while disabled");

	a_syserr_pass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_event.syserr_request && cmd_r[CMD_SYSERR_EN] |-> o_syserr_drive)
		else $error("enabled system error not driven");

	// A disabled response must keep the flag clear even while errors arrive.
	a_parity_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cmd_r[CMD_PARITY_EN] && !st_r[ST_DATA_PAR] |=> !st_r[ST_DATA_PAR])
		else $error("parity flag set while response disabled");

	a_parity_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_event.data_parity_master && cmd_r[CMD_PARITY_EN] |=> st_r[ST_DATA_PAR])
		else $error("data parity flag not set");

	a_det_parity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_event.parity_detected |=> st_r[ST_DET_PARITY])
		else $error("detected parity flag not set");

	a_syserr_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && o_syserr_drive |=> st_r[ST_SIG_SYSERR])
		else $error("system error flag not set");

	a_abort_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_event.master_abort_rcvd |=> st_r[ST_RCV_MABORT])
		else $error("master abort flag not set");

	a_tabort_rcvd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_event.target_abort_rcvd |=> st_r[ST_RCV_TABORT])
		else $error("received target abort flag not set");

	a_tabort_sig: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_event.target_abort_sig |=> st_r[ST_SIG_TABORT])
		else $error("signalled target abort flag not set");

	a_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_st && i_avs_writedata[ST_SIG_TABORT] && i_event.target_abort_sig
		|=> st_r[ST_SIG_TABORT])
		else $error("clear beat a same-cycle set");

	a_w1c_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_st && (st_set & ST_CLEARABLE) == 16'h0000 |=>
		(st_r & $past(st_clr)) == 16'h0000)
		else $error("write one did not clear");

	a_w0_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_st |=> (($past(st_r) & ~$past(st_clr)) & ~st_r) == 16'h0000)
		else $error("status bit lost without a write of one");

	a_st_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_r & ~ST_CLEARABLE) == ST_FIXED)
		else $error("fixed status bits wrong");

	a_ro_status: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_st |=> (st_r & ~ST_CLEARABLE) == ST_FIXED)
		else $error("read-only status bit changed by a write");

	a_status_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && req && i_avs_read && i_avs_address == ADDR_STATUS |=>
		rdata_r == {16'h0000, $past(st_r)})
		else $error("status read data wrong");

	a_unmapped_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && req && i_avs_read && i_avs_address > ADDR_IRQ_MASK |=>
		rdata_r == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_sec_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cmd_r[CMD_MASTER_EN] |-> !o_gate.sec_accept && !o_gate.master_ok)
		else $error("accepted without bus master enable");

	a_master_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cmd_r[CMD_MASTER_EN] |-> !o_gate.master_ok)
		else $error("primary cycle allowed without bus master enable");

	a_fwd_gates: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_gate.fwd_mem == cmd_r[CMD_MEM_EN] && o_gate.fwd_io == cmd_r[CMD_IO_EN])
		else $error("forwarding gate mismatch");

	a_io_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cmd_r[CMD_IO_EN] |-> !o_gate.fwd_io)
		else $error("I/O forwarded while disabled");

	a_no_b2b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!o_gate.fast_b2b)
		else $error("back-to-back offered");

	a_snoop_alias: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cmd_r[CMD_SNOOP_EN] && i_pri_io_write && i_pri_addr[9:0] == 10'h3c8
		|-> o_gate.snoop_fwd)
		else $error("palette alias not forwarded");

	a_snoop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!cmd_r[CMD_SNOOP_EN] || !i_pri_io_write |-> !o_gate.snoop_fwd)
		else $error("palette snoop without enable or write");

	// The first cycle of every request is stalled; with i_ce high the bus answers after one wait cycle.
	a_wait_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		req |-> o_avs_waitrequest)
		else $error("first cycle of a request not stalled");

	a_ack_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		ack_r && i_ce |=> !ack_r)
		else $error("acknowledge longer than one cycle");

	a_mask_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_mask && i_avs_byteenable[0] |=> irq_mask_r == $past(i_avs_writedata[5:0]))
		else $error("interrupt mask write not stored");

	a_read_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		rd_irq && ev_vec == 6'h00 |=> (irq_st_r & $past(rdata_r[5:0])) == 6'h00)
		else $error("interrupt status not cleared by read");

	a_irq_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce |=> (irq_st_r & $past(ev_vec)) == $past(ev_vec))
		else $error("interrupt event lost");

	a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_irq == |(irq_st_r & irq_mask_r))
		else $error("interrupt level wrong");

endmodule
`default_nettype wire

// ### src/bridge_cmd_pkg.sv
// Constants and carrier types for the primary command and status register block.
package bridge_cmd_pkg;

	// Avalon word addresses of the register words.
	localparam logic [3:0] ADDR_COMMAND    = 4'h0;
	localparam logic [3:0] ADDR_STATUS     = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK   = 4'h3;

	// Command bit positions.
	localparam int CMD_IO_EN     = 0;
	localparam int CMD_MEM_EN    = 1;
	localparam int CMD_MASTER_EN = 2;
	localparam int CMD_SPECIAL   = 3;
	localparam int CMD_MWI       = 4;
	localparam int CMD_SNOOP_EN  = 5;
	localparam int CMD_PARITY_EN = 6;
	localparam int CMD_WAIT_CTL  = 7;
	localparam int CMD_SYSERR_EN = 8;
	localparam int CMD_FAST_B2B  = 9;

	// Command bits that software can change.
	localparam logic [15:0] CMD_WRITABLE = 16'h0367;
	localparam logic [15:0] CMD_RESET    = 16'h0000;

	// Status bit positions.
	localparam int ST_DATA_PAR    = 8;
	localparam int ST_SIG_TABORT  = 11;
	localparam int ST_RCV_TABORT  = 12;
	localparam int ST_RCV_MABORT  = 13;
	localparam int ST_SIG_SYSERR  = 14;
	localparam int ST_DET_PARITY  = 15;

	// Status bits that a write of one clears, and the fixed read-only pattern.
	localparam logic [15:0] ST_CLEARABLE = 16'hf900;
	localparam logic [15:0] ST_FIXED     = 16'h0210;
	localparam logic [15:0] ST_RESET     = 16'h0210;

	// Snoop decode: ten address bits compared against the palette ports.
	localparam int          SNOOP_BITS = 10;
	localparam logic [9:0]  PAL_MASK_A = 10'h3c6;
	localparam logic [9:0]  PAL_DATA_A = 10'h3c8;
	localparam logic [9:0]  PAL_DATA_B = 10'h3c9;

	// Hardware events that set status flags, one pulse each.
	typedef struct packed {
		logic parity_detected;
		logic data_parity_master;
		logic master_abort_rcvd;
		logic target_abort_rcvd;
		logic target_abort_sig;
		logic syserr_request;
	} bridge_event_s;

	// Forwarding gates derived from the command word.
	typedef struct packed {
		logic fwd_mem;
		logic fwd_io;
		logic master_ok;
		logic sec_accept;
		logic snoop_fwd;
		logic fast_b2b;
	} fwd_gate_s;

endpackage

// ### src/palette_snoop.sv
// Palette snoop address matcher for primary I/O writes.
`timescale 1ns/1ps
`default_nettype none
module palette_snoop
	import bridge_cmd_pkg::*;
(
	input  wire logic        i_enable,
	input  wire logic        i_io_write,
	input  wire logic [31:0] i_addr,
	output logic             o_hit
);

	logic [9:0] low_addr;

	assign low_addr = i_addr[SNOOP_BITS-1:0];

	assign o_hit = i_enable && i_io_write &&
		(low_addr == PAL_MASK_A || low_addr == PAL_DATA_A || low_addr == PAL_DATA_B);

endmodule
`default_nettype wire

// ### verif/event_source.sv
// Primary bus event source that turns a held request into one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module event_source
	import bridge_cmd_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_rst_n,
	input  wire bridge_event_s i_req,
	output bridge_event_s      o_event
);
	bridge_event_s prev_r;

	// Only the rising edge of a request pulses, since the block counts every high cycle anew.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_r  <= '0;
			o_event <= '0;
		end else begin
			prev_r  <= i_req;
			o_event <= bridge_event_s'(i_req & ~prev_r);
		end
	end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the primary command and status register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import bridge_cmd_pkg::*;
;
	logic          i_clk;
	logic          i_rst_n;
	logic [3:0]    avs_address;
	logic          avs_read;
	logic          avs_write;
	logic [31:0]   avs_writedata;
	logic [31:0]   o_avs_readdata;
	logic          o_avs_waitrequest;
	logic [5:0]    req;
	bridge_event_s evt;
	logic [31:0]   pri_addr;
	logic          io_wr;
	logic          bm_req;
	fwd_gate_s     o_gate;
	logic          o_syserr_drive;
	logic          o_irq;
	logic [31:0]   q;
	logic [31:0]   snoop_addr [4];
	int            mismatches;
	int            checks;

	bridge_primary_command_status u_bridge_primary_command_status (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.i_event(evt), .i_pri_io_write(io_wr), .i_pri_addr(pri_addr),
		.i_pri_master_req(bm_req), .i_sec_mem_io_req(bm_req), .o_gate(o_gate),
		.o_syserr_drive(o_syserr_drive), .o_irq(o_irq)
	);

	event_source u_event_source (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(bridge_event_s'(req)), .o_event(evt)
	);

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// The event request rides with the strobe so its pulse lands on the edge that ends the access.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			input logic [5:0] e, output logic [31:0] r);
		int n;
		n = 0;
		avs_read      <= ~w;
		avs_write     <= w;
		avs_address   <= a;
		avs_writedata <= d;
		req           <= e;
		do begin
			@(posedge i_clk);
			req <= 6'h0;
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		r = o_avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge i_clk);
		if (n >= 50) begin
			mismatches++;
			wrap_up();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 6'h0, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0, 6'h0, q);
		chk(what, q, e);
	endtask

	task automatic fire(input logic [5:0] e, input logic exp_drv);
		req <= e;
		@(posedge i_clk);
		req <= 6'h0;
		#1 chk("system error drive", {31'h0, o_syserr_drive}, {31'h0, exp_drv});
		repeat (4) @(posedge i_clk);
	endtask

	initial begin
		i_rst_n       = 1'b0;
		avs_address   = 4'h0;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		req           = 6'h0;
		pri_addr      = 32'h0000f3c6;
		io_wr         = 1'b1;
		bm_req        = 1'b1;
		mismatches    = 0;
		checks        = 0;
		snoop_addr    = '{32'h0000f3c6, 32'h000013c8, 32'h800003c9, 32'h000003c7};
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rd(ADDR_COMMAND, 32'h0, "command at reset");
		rd(ADDR_STATUS, 32'h210, "status at reset");
		chk("gates closed", {26'h0, o_gate}, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h0);
		wr(ADDR_COMMAND, 32'hffff);
		rd(ADDR_COMMAND, 32'h367, "command writable bits");
		chk("gates open", {26'h0, o_gate}, 32'h3e);
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk);
			pri_addr <= snoop_addr[i];
			@(posedge i_clk);
			#1 chk("palette snoop", {31'h0, o_gate.snoop_fwd}, {31'h0, i < 3});
		end
		@(posedge i_clk);
		io_wr    <= 1'b0;
		bm_req   <= 1'b0;
		pri_addr <= 32'h000003c8;
		@(posedge i_clk);
		#1 chk("gates without requests", {26'h0, o_gate}, 32'h30);
		@(posedge i_clk);
		io_wr  <= 1'b1;
		bm_req <= 1'b1;
		@(posedge i_clk);
		fire(6'h01, 1'b1);
		fire(6'h3f, 1'b1);
		rd(ADDR_STATUS, 32'hfb10, "status after events");
		chk("masked interrupt", {31'h0, o_irq}, 32'h0);
		wr(ADDR_STATUS, 32'h0);
		rd(ADDR_STATUS, 32'hfb10, "status after zero write");
		wr(ADDR_STATUS, 32'hffff);
		rd(ADDR_STATUS, 32'h210, "status after clear");
		wr(ADDR_COMMAND, 32'h0);
		fire(6'h31, 1'b0);
		rd(ADDR_STATUS, 32'h8210, "status with enables clear");
		bus(1'b1, ADDR_STATUS, 32'hffff, 6'h02, q);
		rd(ADDR_STATUS, 32'h0a10, "set beats clear");
		wr(4'h9, 32'hffff);
		rd(4'h9, 32'h0, "unmapped read");
		wr(ADDR_COMMAND, 32'h4);
		bus(1'b0, ADDR_IRQ_STATUS, 32'h0, 6'h0, q);
		wr(ADDR_IRQ_MASK, 32'h3f);
		fire(6'h08, 1'b0);
		chk("interrupt raised", {31'h0, o_irq}, 32'h1);
		rd(ADDR_IRQ_STATUS, 32'h8, "interrupt cause");
		repeat (2) @(posedge i_clk);
		chk("interrupt cleared", {31'h0, o_irq}, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
